// ---- rtl/akw_defs.vh ----
// Constants for the angle-referenced knock window generator.
// Assumes a 125 MHz clock and an angle base in 0.01 degree units.
`ifndef AKW_DEFS_VH
`define AKW_DEFS_VH

`define AKW_ANGLE_W 17
`define AKW_CYCLE_UNITS 17'h11940
`define AKW_ANGLE_MAX 17'h1193F
`define AKW_MAX_WIN 4'h8
`define AKW_ADDR_W 6

`define AKW_OFF_CTRL 6'h00
`define AKW_OFF_STATUS 6'h04
`define AKW_OFF_PBASE 6'h08
`define AKW_OFF_UOPEN 6'h0C
`define AKW_OFF_UWIDTH 6'h10
`define AKW_OFF_UCOMMIT 6'h14
`define AKW_OFF_ANGLE 6'h18

`define AKW_CTRL_EN 0
`define AKW_CTRL_POL 1
`define AKW_CTRL_ISEL 2
`define AKW_CTRL_PRIO_LO 4
`define AKW_CTRL_PRIO_HI 5
`define AKW_CTRL_CNT_LO 8
`define AKW_CTRL_CNT_HI 11
`define AKW_CTRL_RESET 32'h00000100

`define AKW_ST_PEND 0
`define AKW_ST_ACTIVE 1
`define AKW_ST_RUN 2
`define AKW_ST_CFGERR 3
`define AKW_ST_UPDERR 4
`define AKW_ST_WIN_LO 8
`define AKW_ST_WIN_HI 10

`define AKW_POLARITY_ACTIVE_HIGH 1'h0
`define AKW_POLARITY_ACTIVE_LOW 1'h1
`define AKW_IRQ_ON_WINDOW_OPEN 1'h0
`define AKW_IRQ_ON_WINDOW_CLOSE 1'h1
`define AKW_SCHED_PRIO_OFF 2'h0
`define AKW_SCHED_PRIO_LOW 2'h1
`define AKW_SCHED_PRIO_MID 2'h2
`define AKW_SCHED_PRIO_HIGH 2'h3

`define AKW_RESP_OKAY 2'h0
`define AKW_RESP_SLVERR 2'h2

`endif

// ---- rtl/akw_table_mem.v ----
// Window angle table: one word per window, open angle above width.
// Assumes a single clock; read data is registered, one cycle latency.
`timescale 1ns/1ps
module akw_table_mem #(
  parameter DW = 34,
  parameter AW = 3
) (
  input wire clk_in, // Clock.
  input wire we_in, // Write strobe.
  input wire [AW-1:0] waddr_in, // Write index.
  input wire [DW-1:0] wdata_in, // Open and width pair.
  input wire [AW-1:0] raddr_in, // Read index.
  output reg [DW-1:0] rdata_out // Registered read data.
);
  reg [DW-1:0] mem [0:(1<<AW)-1];

  // A whole pair lands in one write, so a reader never sees half of it.
  always @(posedge clk_in) begin
    if (we_in) begin
      mem[waddr_in] <= wdata_in;
    end
    rdata_out <= mem[raddr_in];
  end
endmodule // akw_table_mem

// ---- rtl/akw_top.v ----
// Knock window generator channel with an AXI4-Lite register slave.
// Assumes the angle base and link pulse come from logic on clk_in.
`timescale 1ns/1ps
`include "akw_defs.vh"
module akw_top (
  input wire clk_in, // 125 MHz clock.
  input wire resetn_in, // Asynchronous reset, active low.
  input wire [16:0] angle_in, // Crank angle, 0.01 degree units.
  input wire angle_ok_in, // Angle base is valid.
  input wire link_in, // Link from another channel, pulse.
  output reg window_out, // Knock window pin.
  output reg irq_pending_out, // Pending interrupt flag.
  input wire [5:0] s_axi_awaddr, // Write address.
  input wire s_axi_awvalid, // Write address valid.
  output reg s_axi_awready, // Write address ready.
  input wire [31:0] s_axi_wdata, // Write data.
  input wire [3:0] s_axi_wstrb, // Write strobes.
  input wire s_axi_wvalid, // Write data valid.
  output reg s_axi_wready, // Write data ready.
  output reg [1:0] s_axi_bresp, // Write response.
  output reg s_axi_bvalid, // Write response valid.
  input wire s_axi_bready, // Write response ready.
  input wire [5:0] s_axi_araddr, // Read address.
  input wire s_axi_arvalid, // Read address valid.
  output reg s_axi_arready, // Read address ready.
  output reg [31:0] s_axi_rdata, // Read data.
  output reg [1:0] s_axi_rresp, // Read response.
  output reg s_axi_rvalid, // Read data valid.
  input wire s_axi_rready // Read data ready.
);
  localparam ST_IDLE = 3'h0;
  localparam ST_FETCH = 3'h1;
  localparam ST_LOAD = 3'h2;
  localparam ST_ARM = 3'h3;
  localparam ST_OPEN = 3'h4;
  localparam [31:0] CTRL_RST = `AKW_CTRL_RESET;

  // True when target lies in (prev, cur], allowing for the 720 degree wrap.
  function hit;
    input [16:0] prev;
    input [16:0] cur;
    input [16:0] tgt;
    begin
      if (prev <= cur) begin
        hit = (tgt > prev) && (tgt <= cur);
      end else begin
        hit = (tgt > prev) || (tgt <= cur);
      end
    end
  endfunction

  function [31:0] merge;
    input [31:0] old;
    input [31:0] nw;
    input [3:0] strb;
    integer i;
    begin
      merge = old;
      for (i = 0; i < 4; i = i + 1) begin
        if (strb[i]) begin
          merge[i*8 +: 8] = nw[i*8 +: 8];
        end
      end
    end
  endfunction

  // Control fields.
  reg en_q;
  reg pol_q;
  reg isel_q;
  reg [1:0] prio_q;
  reg [3:0] cnt_q;
  reg [31:0] pbase_q;
  reg [16:0] uopen_q;
  reg [16:0] uwidth_q;

  // Engine state.
  reg [2:0] state_q;
  reg [2:0] idx_q;
  reg [16:0] open_q;
  reg [16:0] close_q;
  reg wzero_q;
  reg active_q;
  reg pend_q;
  reg upderr_q;
  reg [16:0] prev_q;

  // Bus slave state.
  reg aw_full_q;
  reg w_full_q;
  reg [5:0] aw_addr_q;
  reg [31:0] w_data_q;
  reg [3:0] w_strb_q;

  wire [33:0] tbl_rdata;
  wire [16:0] tbl_width = tbl_rdata[16:0];
  wire [16:0] tbl_open = tbl_rdata[33:17];
  wire [17:0] close_sum = {1'b0, tbl_open} + {1'b0, tbl_width};

  wire cnt_ok = (cnt_q != 4'h0) && (cnt_q <= `AKW_MAX_WIN);
  wire go = en_q && (prio_q != `AKW_SCHED_PRIO_OFF) && cnt_ok;
  wire last_win = (({1'b0, idx_q} + 4'h1) >= cnt_q);

  wire do_wr = aw_full_q && w_full_q && !s_axi_bvalid;
  wire [5:0] wr_off = {aw_addr_q[5:2], 2'h0};
  wire [5:0] rd_off = {s_axi_araddr[5:2], 2'h0};
  wire [3:0] ucommit_num = w_data_q[3:0];
  wire ucommit_ok = (ucommit_num != 4'h0) && (ucommit_num <= `AKW_MAX_WIN);
  wire wr_commit = do_wr && (wr_off == `AKW_OFF_UCOMMIT) && w_strb_q[0];
  wire tbl_we = wr_commit && ucommit_ok;
  wire [2:0] tbl_waddr = ucommit_num[2:0] - 3'h1;
  wire wr_status = do_wr && (wr_off == `AKW_OFF_STATUS) && w_strb_q[0];
  wire clr_pend = wr_status && w_data_q[`AKW_ST_PEND];
  wire clr_upderr = wr_status && w_data_q[`AKW_ST_UPDERR];
  wire [31:0] uopen_mrg = merge({15'h0000, uopen_q}, w_data_q, w_strb_q);
  wire [31:0] uwidth_mrg = merge({15'h0000, uwidth_q}, w_data_q, w_strb_q);

  reg [31:0] ctrl_rd;
  reg [31:0] status_rd;
  reg [31:0] ctrl_wr;
  reg mapped_rd;
  reg [31:0] rdata_d;
  reg mapped_wr;

  always @* begin
    ctrl_rd = 32'h00000000;
    ctrl_rd[`AKW_CTRL_EN] = en_q;
    ctrl_rd[`AKW_CTRL_POL] = pol_q;
    ctrl_rd[`AKW_CTRL_ISEL] = isel_q;
    ctrl_rd[`AKW_CTRL_PRIO_HI:`AKW_CTRL_PRIO_LO] = prio_q;
    ctrl_rd[`AKW_CTRL_CNT_HI:`AKW_CTRL_CNT_LO] = cnt_q;
    ctrl_wr = merge(ctrl_rd, w_data_q, w_strb_q);
    status_rd = 32'h00000000;
    status_rd[`AKW_ST_PEND] = pend_q;
    status_rd[`AKW_ST_ACTIVE] = active_q;
    status_rd[`AKW_ST_RUN] = (state_q != ST_IDLE);
    status_rd[`AKW_ST_CFGERR] = !cnt_ok;
    status_rd[`AKW_ST_UPDERR] = upderr_q;
    status_rd[`AKW_ST_WIN_HI:`AKW_ST_WIN_LO] = idx_q;
  end

  always @* begin
    mapped_rd = 1'b1;
    rdata_d = 32'h00000000;
    case (rd_off)
      `AKW_OFF_CTRL: rdata_d = ctrl_rd;
      `AKW_OFF_STATUS: rdata_d = status_rd;
      `AKW_OFF_PBASE: rdata_d = pbase_q;
      `AKW_OFF_UOPEN: rdata_d = {15'h0000, uopen_q};
      `AKW_OFF_UWIDTH: rdata_d = {15'h0000, uwidth_q};
      `AKW_OFF_UCOMMIT: rdata_d = 32'h00000000;
      `AKW_OFF_ANGLE: rdata_d = {15'h0000, prev_q};
      default: mapped_rd = 1'b0;
    endcase
  end

  always @* begin
    case (wr_off)
      `AKW_OFF_CTRL: mapped_wr = 1'b1;
      `AKW_OFF_STATUS: mapped_wr = 1'b1;
      `AKW_OFF_PBASE: mapped_wr = 1'b1;
      `AKW_OFF_UOPEN: mapped_wr = 1'b1;
      `AKW_OFF_UWIDTH: mapped_wr = 1'b1;
      `AKW_OFF_UCOMMIT: mapped_wr = 1'b1;
      `AKW_OFF_ANGLE: mapped_wr = 1'b1;
      default: mapped_wr = 1'b0;
    endcase
  end

  akw_table_mem #(
    .DW(34),
    .AW(3)
  ) u_table (
    .clk_in(clk_in),
    .we_in(tbl_we),
    .waddr_in(tbl_waddr),
    .wdata_in({uopen_q, uwidth_q}),
    .raddr_in(idx_q),
    .rdata_out(tbl_rdata)
  );

  // Write channels are taken independently; the response waits for both.
  always @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      aw_full_q <= 1'b0;
      w_full_q <= 1'b0;
      aw_addr_q <= 6'h00;
      w_data_q <= 32'h00000000;
      w_strb_q <= 4'h0;
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `AKW_RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_full_q <= 1'b1;
        aw_addr_q <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_full_q <= 1'b1;
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (do_wr) begin
        aw_full_q <= 1'b0;
        w_full_q <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= mapped_wr ? `AKW_RESP_OKAY : `AKW_RESP_SLVERR;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  always @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `AKW_RESP_OKAY;
    end else begin
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rdata_d;
        s_axi_rresp <= mapped_rd ? `AKW_RESP_OKAY : `AKW_RESP_SLVERR;
      end
      if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

  // Configuration registers written by software.
  always @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      en_q <= CTRL_RST[`AKW_CTRL_EN];
      pol_q <= `AKW_POLARITY_ACTIVE_HIGH;
      isel_q <= `AKW_IRQ_ON_WINDOW_OPEN;
      prio_q <= `AKW_SCHED_PRIO_OFF;
      cnt_q <= CTRL_RST[`AKW_CTRL_CNT_HI:`AKW_CTRL_CNT_LO];
      pbase_q <= 32'h00000000;
      uopen_q <= 17'h00000;
      uwidth_q <= 17'h00000;
      upderr_q <= 1'b0;
    end else begin
      if (do_wr && (wr_off == `AKW_OFF_CTRL)) begin
        en_q <= ctrl_wr[`AKW_CTRL_EN];
        pol_q <= ctrl_wr[`AKW_CTRL_POL];
        isel_q <= ctrl_wr[`AKW_CTRL_ISEL];
        prio_q <= ctrl_wr[`AKW_CTRL_PRIO_HI:`AKW_CTRL_PRIO_LO];
        cnt_q <= ctrl_wr[`AKW_CTRL_CNT_HI:`AKW_CTRL_CNT_LO];
      end
      if (do_wr && (wr_off == `AKW_OFF_PBASE)) begin
        pbase_q <= merge(pbase_q, w_data_q, w_strb_q);
      end
      if (do_wr && (wr_off == `AKW_OFF_UOPEN)) begin
        uopen_q <= uopen_mrg[16:0];
      end
      if (do_wr && (wr_off == `AKW_OFF_UWIDTH)) begin
        uwidth_q <= uwidth_mrg[16:0];
      end
      // A bad window number is flagged; the flag survives a same-cycle clear.
      if (wr_commit && !ucommit_ok) begin
        upderr_q <= 1'b1;
      end else if (clr_upderr) begin
        upderr_q <= 1'b0;
      end
    end
  end

  // Window engine. Each window's pair is fetched just before it is armed,
  // so an update lands at its next occurrence, never mid-pulse.
  always @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      state_q <= ST_IDLE;
      idx_q <= 3'h0;
      open_q <= 17'h00000;
      close_q <= 17'h00000;
      wzero_q <= 1'b0;
      active_q <= 1'b0;
      pend_q <= 1'b0;
      prev_q <= 17'h00000;
    end else begin
      if (angle_ok_in) begin
        prev_q <= angle_in;
      end
      if (link_in) begin
        state_q <= go ? ST_FETCH : ST_IDLE;
        idx_q <= 3'h0;
        active_q <= 1'b0;
        pend_q <= 1'b0;
        wzero_q <= 1'b0;
        open_q <= 17'h00000;
        close_q <= 17'h00000;
      end else if (!go) begin
        state_q <= ST_IDLE;
        idx_q <= 3'h0;
        active_q <= 1'b0;
        if (clr_pend) begin
          pend_q <= 1'b0;
        end
      end else begin
        case (state_q)
          ST_IDLE: begin
            state_q <= ST_FETCH;
          end
          ST_FETCH: begin
            state_q <= ST_LOAD;
          end
          ST_LOAD: begin
            open_q <= tbl_open;
            if (close_sum >= {1'b0, `AKW_CYCLE_UNITS}) begin
              close_q <= close_sum[16:0] - `AKW_CYCLE_UNITS;
            end else begin
              close_q <= close_sum[16:0];
            end
            wzero_q <= (tbl_width == 17'h00000);
            state_q <= ST_ARM;
          end
          ST_ARM: begin
            if (angle_ok_in && hit(prev_q, angle_in, open_q)) begin
              active_q <= 1'b1;
              state_q <= ST_OPEN;
            end
          end
          ST_OPEN: begin
            if (wzero_q || (angle_ok_in && hit(prev_q, angle_in, close_q))) begin
              active_q <= 1'b0;
              idx_q <= last_win ? 3'h0 : idx_q + 3'h1;
              state_q <= ST_FETCH;
            end
          end
          default: begin
            state_q <= ST_IDLE;
          end
        endcase
        // Hardware set wins over a software clear in the same cycle.
        if ((state_q == ST_ARM) && angle_ok_in && hit(prev_q, angle_in, open_q) &&
            (isel_q == `AKW_IRQ_ON_WINDOW_OPEN)) begin
          pend_q <= 1'b1;
        end else if ((state_q == ST_OPEN) && (isel_q == `AKW_IRQ_ON_WINDOW_CLOSE) &&
                     (wzero_q || (angle_ok_in && hit(prev_q, angle_in, close_q)))) begin
          pend_q <= 1'b1;
        end else if (clr_pend) begin
          pend_q <= 1'b0;
        end
      end
    end
  end

  // Pin and flag outputs come from flops; the pin trails the state by one.
  always @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      window_out <= 1'b0;
      irq_pending_out <= 1'b0;
    end else begin
      window_out <= active_q ^ (pol_q == `AKW_POLARITY_ACTIVE_LOW);
      irq_pending_out <= pend_q;
    end
  end
endmodule // akw_top

// ---- test/akw_angle_model.sv ----
// Crank angle base model: steps the angle a fixed amount each clock.
// Assumes the bench starts and stops it; a stopped base shows no usable angle.
`timescale 1ns/1ps
module akw_angle_model (
  input logic clk_in, // Clock.
  input logic resetn_in, // Reset, active low.
  input logic run_in, // Base running.
  input logic [16:0] step_in, // Step per clock.
  output logic [16:0] angle_out, // Crank angle.
  output logic angle_ok_out // Angle valid.
);
  logic [16:0] angle_q;
  logic [17:0] sum;
  assign sum = angle_q + step_in;
  // Inverted while invalid, so a stale angle cannot be mistaken for a good one.
  assign angle_out = run_in ? angle_q : ~angle_q;
  assign angle_ok_out = run_in;
  always @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) angle_q <= 17'h00000;
    else if (run_in) angle_q <= (sum >= 18'h11940) ? sum[16:0] - 17'h11940 : sum[16:0];
  end
endmodule // akw_angle_model

// ---- test/akw_properties.sv ----
// Checker for the knock window channel: bus answers, window level, pending flag.
// Assumes writes offer address and data together with all byte strobes.
`timescale 1ns/1ps
module akw_properties (
  input logic clk_in, // Clock.
  input logic resetn_in, // Reset, active low.
  input logic link_in, // Link pulse.
  input logic window_out, // Window pin.
  input logic irq_pending_out, // Pending flag.
  input logic [5:0] s_axi_awaddr, // Bus.
  input logic s_axi_awvalid, // Bus.
  input logic s_axi_awready, // Bus.
  input logic [31:0] s_axi_wdata, // Bus.
  input logic s_axi_wvalid, // Bus.
  input logic s_axi_wready, // Bus.
  input logic s_axi_bvalid, // Bus.
  input logic s_axi_arvalid, // Bus.
  input logic s_axi_arready, // Bus.
  input logic s_axi_rvalid // Bus.
);
  logic [5:0] ctrl_q;
  logic [2:0] quiet_q;
  wire wr_hs = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  // A control write moves the pin a few cycles later, so level checks wait for it to settle.
  wire quiet = quiet_q == 3'h7;
  wire act = window_out ^ ctrl_q[1];
  always @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      ctrl_q <= 6'h00;
      quiet_q <= 3'h0;
    end else if (wr_hs && s_axi_awaddr[5:2] == 4'h0) begin
      ctrl_q <= s_axi_wdata[5:0];
      quiet_q <= 3'h0;
    end else if (!quiet) begin
      quiet_q <= quiet_q + 3'h1;
    end
  end
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!resetn_in);
  wr_latency_a: assert property (wr_hs |=> !s_axi_bvalid ##1 s_axi_bvalid)
    else $error("write answer late");
  rd_latency_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  wr_block_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while busy");
  rd_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while busy");
  idle_level_a: assert property (quiet && (!ctrl_q[0] || ctrl_q[5:4] == 2'h0) |-> !act)
    else $error("idle pin not at inactive level");
  open_pend_a: assert property (quiet && !ctrl_q[2] && $rose(act) |-> irq_pending_out)
    else $error("open did not set pending");
  close_pend_a: assert property (quiet && ctrl_q[2] && $fell(act) && !$past(link_in) && !$past(link_in, 2) |-> irq_pending_out)
    else $error("close did not set pending");
  link_clear_a: assert property (link_in && quiet |=> ##1 !irq_pending_out && !act)
    else $error("link did not clear state");
endmodule // akw_properties
bind akw_top akw_properties chk_u (.clk_in, .resetn_in, .link_in, .window_out, .irq_pending_out, .s_axi_awaddr,
  .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rvalid);

// ---- test/tb_angle_knock_window_generator.sv ----
// Self-checking bench for the knock window channel.
// Assumes the angle base steps 5 degrees a clock, so one engine cycle is 144 clocks.
`timescale 1ns/1ps
`include "akw_defs.vh"
module tb_angle_knock_window_generator;
  typedef struct packed {logic we; logic [5:0] a; logic [31:0] d; logic [31:0] e; logic [1:0] r;} akw_row_t;
  akw_row_t rows [0:7] = '{
    '{1'h0, `AKW_OFF_CTRL, 32'h0, 32'h100, `AKW_RESP_OKAY},
    '{1'h0, `AKW_OFF_STATUS, 32'h0, 32'h0, `AKW_RESP_OKAY},
    '{1'h0, `AKW_OFF_PBASE, 32'h0, 32'h0, `AKW_RESP_OKAY},
    '{1'h1, `AKW_OFF_PBASE, 32'h1234ABCD, 32'h0, `AKW_RESP_OKAY},
    '{1'h0, `AKW_OFF_PBASE, 32'h0, 32'h1234ABCD, `AKW_RESP_OKAY},
    '{1'h1, 6'h1C, 32'h5, 32'h0, `AKW_RESP_SLVERR},
    '{1'h0, 6'h1C, 32'h0, 32'h0, `AKW_RESP_SLVERR},
    '{1'h0, `AKW_OFF_UCOMMIT, 32'h0, 32'h0, `AKW_RESP_OKAY}};
  logic [3:0] cnts [0:2] = '{4'h0, 4'h8, 4'h9};
  logic clk_in = 1'h0, resetn_in = 1'h0, link_in = 1'h0, run = 1'h0;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic [5:0] s_axi_awaddr = 6'h00, s_axi_araddr = 6'h00;
  logic [31:0] s_axi_wdata = 32'h0, rd;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0, s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  logic [1:0] rsp;
  logic [16:0] angle_in;
  logic angle_ok_in;
  wire window_out, irq_pending_out, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  integer failures = 0, check_count = 0, cyc = 0, hi_cnt, edge_cnt, i;
  akw_angle_model mdl_u (.clk_in, .resetn_in, .run_in(run), .step_in(17'h001F4), .angle_out(angle_in),
    .angle_ok_out(angle_ok_in));
  akw_top dut_u (.clk_in, .resetn_in, .angle_in, .angle_ok_in, .link_in, .window_out, .irq_pending_out,
    .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
  initial forever #4 clk_in = ~clk_in;
  task automatic finish_test();
    $display("checks %0d mismatches %0d", check_count, failures);
    if (failures == 0 && check_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  always @(posedge clk_in) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      failures = failures + 1;
      finish_test();
    end
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      failures++;
      $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // One access at a time; each channel is held until its own ready is sampled.
  task automatic rw(input logic we, input logic [5:0] a, input logic [31:0] d);
    logic ad;
    logic dd;
    ad = 1'h0;
    dd = !we;
    @(posedge clk_in);
    s_axi_awaddr <= a;
    s_axi_araddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= we;
    s_axi_wvalid <= we;
    s_axi_arvalid <= !we;
    s_axi_bready <= we;
    s_axi_rready <= !we;
    while (!(ad && dd)) begin
      @(posedge clk_in);
      if (!ad && (we ? s_axi_awready : s_axi_arready)) begin
        ad = 1'h1;
        s_axi_awvalid <= 1'h0;
        s_axi_arvalid <= 1'h0;
      end
      if (!dd && s_axi_wready) begin
        dd = 1'h1;
        s_axi_wvalid <= 1'h0;
      end
    end
    do @(posedge clk_in); while (!(we ? s_axi_bvalid : s_axi_rvalid));
    rd = s_axi_rdata;
    rsp = we ? s_axi_bresp : s_axi_rresp;
    s_axi_bready <= 1'h0;
    s_axi_rready <= 1'h0;
  endtask
  task automatic tbl(input logic [31:0] n, input logic [31:0] o, input logic [31:0] w);
    rw(1'h1, `AKW_OFF_UOPEN, o);
    rw(1'h1, `AKW_OFF_UWIDTH, w);
    rw(1'h1, `AKW_OFF_UCOMMIT, n);
  endtask
  task automatic measure(input logic lvl);
    logic prev;
    hi_cnt = 0;
    edge_cnt = 0;
    prev = window_out;
    repeat (144) begin
      @(posedge clk_in);
      if (window_out === lvl) hi_cnt++;
      if (window_out === lvl && prev !== lvl) edge_cnt++;
      prev = window_out;
    end
  endtask
  initial begin
    repeat (10) @(posedge clk_in);
    resetn_in <= 1'h1;
    run <= 1'h1;
    for (i = 0; i < 8; i++) begin
      rw(rows[i].we, rows[i].a, rows[i].d);
      chk(rsp, rows[i].r);
      if (!rows[i].we) chk(rd, rows[i].e);
    end
    // Only the low byte lane is enabled, so the rest of the base must survive.
    s_axi_wstrb <= 4'h1;
    rw(1'h1, `AKW_OFF_PBASE, 32'hFFFFFFFF);
    s_axi_wstrb <= 4'hF;
    rw(1'h0, `AKW_OFF_PBASE, 32'h0);
    chk(rd, 32'h1234ABFF);
    $display("test registers done");
    tbl(32'h1, 32'h02710, 32'h01388);
    tbl(32'h2, 32'h11170, 32'h01388);
    rw(1'h1, `AKW_OFF_UCOMMIT, 32'h0);
    rw(1'h0, `AKW_OFF_STATUS, 32'h0);
    chk(rd[4], 1'h1);
    rw(1'h1, `AKW_OFF_STATUS, 32'h10);
    rw(1'h0, `AKW_OFF_STATUS, 32'h0);
    chk(rd[4], 1'h0);
    for (i = 0; i < 3; i++) begin
      rw(1'h1, `AKW_OFF_CTRL, {20'h0, cnts[i], 8'h31});
      rw(1'h0, `AKW_OFF_STATUS, 32'h0);
      chk(rd[3:2], (cnts[i] == 4'h8) ? 2'h1 : 2'h2);
    end
    for (i = 0; i < 4; i++) begin
      rw(1'h1, `AKW_OFF_CTRL, 32'h201 | (i << 4));
      rw(1'h0, `AKW_OFF_STATUS, 32'h0);
      chk(rd[2], i != 0);
    end
    $display("test config done");
    repeat (144) @(posedge clk_in);
    measure(1'h1);
    chk(hi_cnt, 32'h14);
    chk(edge_cnt, 32'h2);
    chk(irq_pending_out, 1'h1);
    tbl(32'h1, 32'h07530, 32'h009C4);
    repeat (288) @(posedge clk_in);
    measure(1'h1);
    chk(hi_cnt, 32'h0F);
    $display("test windows done");
    link_in <= 1'h1;
    @(posedge clk_in);
    link_in <= 1'h0;
    repeat (2) @(posedge clk_in);
    chk(irq_pending_out, 1'h0);
    repeat (144) @(posedge clk_in);
    measure(1'h1);
    chk(edge_cnt, 32'h2);
    run <= 1'h0;
    // An open decided on the last valid angle still reaches the pin one clock later.
    repeat (3) @(posedge clk_in);
    measure(1'h1);
    chk(edge_cnt, 32'h0);
    run <= 1'h1;
    $display("test link done");
    rw(1'h1, `AKW_OFF_CTRL, 32'h230);
    rw(1'h1, `AKW_OFF_STATUS, 32'h1);
    rw(1'h0, `AKW_OFF_STATUS, 32'h0);
    chk(rd[0], 1'h0);
    rw(1'h1, `AKW_OFF_CTRL, 32'h237);
    repeat (4) @(posedge clk_in);
    do @(posedge clk_in); while (window_out !== 1'h0);
    chk(irq_pending_out, 1'h0);
    do @(posedge clk_in); while (window_out !== 1'h1);
    repeat (2) @(posedge clk_in);
    chk(irq_pending_out, 1'h1);
    measure(1'h0);
    chk(hi_cnt, 32'h0F);
    chk(edge_cnt, 32'h2);
    $display("test polarity done");
    resetn_in <= 1'h0;
    repeat (2) @(posedge clk_in);
    chk(window_out, 1'h0);
    chk(irq_pending_out, 1'h0);
    resetn_in <= 1'h1;
    rw(1'h0, `AKW_OFF_CTRL, 32'h0);
    chk(rd, 32'h100);
    rw(1'h0, `AKW_OFF_STATUS, 32'h0);
    chk(rd, 32'h0);
    $display("test reset done");
    finish_test();
  end
endmodule // tb_angle_knock_window_generator
